/* stc_regs.vh */
// Purpose: Constants for the sync trigger conditioner
// Assumes: 100 MHz clock, classic Wishbone slave, 32-bit data
// Notes:   Byte addresses; each register is one aligned word
//
// Behaviour
// - Two sync input lines, one output line.
// - Line directions are fixed, never swapped.
// - Output can give a 1 Hz reference.
// - The 1 Hz reference follows receiver second pulse.
// - Triggers are pulse waves, in and out.
// - Line selector: input, software request, output.
// - Software request only feeds send-latest function.
// - Polarity selects rising, falling or both edges.
// - First n qualifying edges are discarded.
// - Periodic skip ignores n edges between triggers.
// - Periodic skip starts after initial skip.
// - Single-shot fires once, ignores later pulses.
// - Single-shot counts only after initial skip.
// - Entering measurement mode clears single-shot state.
// - Per-function pulse width in microseconds, on the output line only.
// - Per-function reaction delay in microseconds.
// - Clock-lock line rejects other functions there.
`ifndef STC_REGS_VH
`define STC_REGS_VH

// Register byte addresses
`define STC_A_CTRL     8'h00
`define STC_A_STAT     8'h04
`define STC_A_SLOT0    8'h10
`define STC_SLOT_N     4

// Control register bits
`define STC_C_SWREQ    0
`define STC_C_RELOAD   1

// Slot config and timing word fields
`define STC_F_EN       0
`define STC_F_LINE     2:1
`define STC_F_POL      4:3
`define STC_F_ONCE     5
`define STC_F_KIND     8:6
`define STC_F_SKIPI    23:16
`define STC_F_SKIPP    31:24
`define STC_F_DLY      15:0
`define STC_F_WID      31:16

// Line selector codes
`define STC_L_IN0      2'h0
`define STC_L_IN1      2'h1
`define STC_L_SWREQ    2'h2
`define STC_L_OUT      2'h3

// Polarity codes
`define STC_P_RISE     2'h1
`define STC_P_FALL     2'h2
`define STC_P_BOTH     2'h3

// Function kinds
`define STC_K_MARK     3'h0
`define STC_K_LATEST   3'h1
`define STC_K_START    3'h2
`define STC_K_LOCK     3'h3
`define STC_K_IVL      3'h4
`define STC_K_REF1HZ   3'h5

// Timing
`define STC_CLK_MHZ    100
`define STC_US_CYC     7'h64
`define STC_IVL_US     12'h9c4

// Reset values
`define STC_CFG_RST    32'h0000_0000
`define STC_TIM_RST    32'h0000_0000
`endif

/* stc_edge.v */
// Purpose: Synchronise one line and report its edges
// Assumes: Line is asynchronous to clk
// Notes:   First stage is read only by the second stage
`include "stc_regs.vh"
module stc_edge (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Raw line and edge pulses
  input  wire line_i,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_q;  // First stage
  reg sync_q;  // Second stage
  reg last_q;  // Previous synced level

  // Two-flop synchroniser and history
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= line_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge pulses from stable stages only
  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;
  assign fall_o  = ~sync_q & last_q;
endmodule

/* stc_chan.v */
// Purpose: One function slot: skip, single-shot, delay, width
// Assumes: edge_i already filtered by polarity and line
// Notes:   Triggers arriving while a delay runs are dropped
`include "stc_regs.vh"
module stc_chan (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Control
  input  wire        reload_i,
  input  wire        clr_once_i,
  input  wire        us_tick_i,
  input  wire        edge_i,
  // Settings
  input  wire        once_i,
  input  wire [7:0]  skipi_i,
  input  wire [7:0]  skipp_i,
  input  wire [15:0] dly_i,
  input  wire [15:0] wid_i,
  // Results
  output reg         fire_o,
  output reg         pulse_o,
  output wire        spent_o
);
  reg [7:0]  init_q;  // Initial skips left
  reg [7:0]  per_q;   // Periodic skips left
  reg        spent_q; // Single-shot used
  reg        pend_q;  // Delay running
  reg [15:0] dly_q;   // Delay left, us
  reg [15:0] wid_q;   // Width left, us
  wire       zero_dly;// No reaction delay set
  wire       go;      // Delay over: fire this cycle

  assign spent_o  = spent_q;
  assign zero_dly = (dly_i == 16'h0000);
  assign go       = pend_q & (us_tick_i | zero_dly) & (dly_q == 16'h0000);

  // Qualification chain and timers
  always @(posedge clk)
  begin
    fire_o <= 1'b0;
    if (rst | reload_i)
    begin
      init_q  <= skipi_i;
      per_q   <= 8'h00;
      spent_q <= 1'b0;
      pend_q  <= 1'b0;
      dly_q   <= 16'h0000;
      wid_q   <= 16'h0000;
      pulse_o <= 1'b0;
    end
    else
    begin
      if (clr_once_i)
        spent_q <= 1'b0;
      // Edge qualification in fixed order
      if (edge_i & ~pend_q)
      begin
        if (init_q != 8'h00)
          init_q <= init_q - 8'h01;
        else if (per_q != 8'h00)
          per_q <= per_q - 8'h01;
        else if (~(once_i & spent_q))
        begin
          per_q   <= skipp_i;
          spent_q <= once_i;
          pend_q  <= 1'b1;
          dly_q   <= dly_i;
        end
      end
      // Reaction delay in microsecond steps; the prescaler runs free,
      // so one extra tick keeps the delay at least the set value
      if (pend_q & (us_tick_i | zero_dly))
      begin
        if (dly_q == 16'h0000)
        begin
          pend_q  <= 1'b0;
          fire_o  <= 1'b1;
          pulse_o <= (wid_i != 16'h0000);
          wid_q   <= wid_i;
        end
        else
          dly_q <= dly_q - 16'h0001;
      end
      // Pulse width in microsecond steps, ended on a tick for the same reason
      if (pulse_o & us_tick_i & ~go)
      begin
        if (wid_q == 16'h0000)
          pulse_o <= 1'b0;
        else
          wid_q <= wid_q - 16'h0001;
      end
    end
  end
endmodule

/* stc_top.v */
// Purpose: Sync trigger conditioner with Wishbone registers
// Assumes: Classic Wishbone, one wait state per access
// Notes:   Four function slots; output line is OR of output-line slots
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`include "stc_regs.vh"
module stc_top (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Sync lines
  input  wire [1:0]  sync_input_line,
  input  wire        receiver_second_pulse,
  output reg         sync_output_line,
  // Device side
  input  wire        meas_mode_enter,
  output reg         mark_event,
  output reg         latest_event,
  output reg         start_event,
  output reg         lock_event
);
  // Fixed line directions: inputs only read, output only driven

  // Slot storage
  reg [31:0] cfg_q [0:`STC_SLOT_N-1];  // Config words
  reg [31:0] tim_q [0:`STC_SLOT_N-1];  // Delay and width

  // Control strobes
  reg        swreq_q;   // Software request pulse
  reg        reload_q;  // Counter reload pulse
  reg [6:0]  us_cnt_q;  // Microsecond prescaler
  reg        us_tick_q; // One pulse per us
  reg [11:0] ivl_cnt_q; // Sample interval counter
  reg        ivl_tick_q;// Internal sample tick

  // Edge detector outputs
  wire [1:0] in_lvl;    // Synced input levels
  wire [1:0] in_rise;   // Input rising edges
  wire [1:0] in_fall;   // Input falling edges
  wire       pps_rise;  // Receiver second pulse edge

  // Slot results
  wire [`STC_SLOT_N-1:0] fire;   // Slot fired
  wire [`STC_SLOT_N-1:0] pulse;  // Slot pulse level
  wire [`STC_SLOT_N-1:0] spent;  // Single-shot used
  reg  [`STC_SLOT_N-1:0] edge_s; // Slot edge input
  reg  [`STC_SLOT_N-1:0] ok_s;   // Slot allowed to run
  reg  [`STC_SLOT_N-1:0] bad_s;  // Enabled but refused

  // Bus decode
  wire       req;       // New access
  wire       is_slot;   // Address in slot range
  wire [1:0] slot_ix;   // Slot index
  wire       slot_tim;  // Timing word selected
  wire [7:0] slot_off;  // Offset into the slot window
  wire [31:0] wmask;    // Byte-lane mask
  integer    k;         // Admission loop index
  integer    j;         // Inner loop index
  integer    m;         // Output loop index
  integer    n;         // Reset loop index

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Slot window: eight bytes per slot, config word then timing word
  assign slot_off = wb_adr_i - `STC_A_SLOT0;
  assign is_slot  = (wb_adr_i >= `STC_A_SLOT0) &
                    (slot_off[7:5] == 3'h0);
  // Slot index and word select come from the window offset
  assign slot_ix  = slot_off[4:3];
  assign slot_tim = slot_off[2];
  assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Input line synchronisers
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gin
      stc_edge u_in (
        .clk     (clk),
        .rst     (rst),
        .line_i  (sync_input_line[g]),
        .level_o (in_lvl[g]),
        .rise_o  (in_rise[g]),
        .fall_o  (in_fall[g])
      );
    end
  endgenerate

  // Receiver second pulse synchroniser
  stc_edge u_pps (
    .clk     (clk),
    .rst     (rst),
    .line_i  (receiver_second_pulse),
    .level_o (),
    .rise_o  (pps_rise),
    .fall_o  ()
  );

  // Microsecond prescaler and sample interval
  always @(posedge clk)
  begin
    if (rst)
    begin
      us_cnt_q   <= 7'h00;
      us_tick_q  <= 1'b0;
      ivl_cnt_q  <= 12'h000;
      ivl_tick_q <= 1'b0;
    end
    else
    begin
      us_tick_q  <= 1'b0;
      ivl_tick_q <= 1'b0;
      if (us_cnt_q == `STC_US_CYC - 7'h01)
      begin
        us_cnt_q  <= 7'h00;
        us_tick_q <= 1'b1;
      end
      else
        us_cnt_q <= us_cnt_q + 7'h01;
      // Interval tick each period of the sample clock
      if (us_tick_q)
      begin
        if (ivl_cnt_q == `STC_IVL_US - 12'h001)
        begin
          ivl_cnt_q  <= 12'h000;
          ivl_tick_q <= 1'b1;
        end
        else
          ivl_cnt_q <= ivl_cnt_q + 12'h001;
      end
    end
  end

  // Slot admission and edge routing
  always @*
  begin
    ok_s   = {`STC_SLOT_N{1'b0}};
    bad_s  = {`STC_SLOT_N{1'b0}};
    edge_s = {`STC_SLOT_N{1'b0}};
    for (k = 0; k < `STC_SLOT_N; k = k + 1)
    begin
      ok_s[k] = cfg_q[k][`STC_F_EN];
      case (cfg_q[k][`STC_F_LINE])
        `STC_L_IN0, `STC_L_IN1:
        begin
          // Input lines carry input functions only
          if (cfg_q[k][`STC_F_KIND] > `STC_K_LOCK)
            ok_s[k] = 1'b0;
          // A lock elsewhere on this line refuses the slot
          for (j = 0; j < `STC_SLOT_N; j = j + 1)
            if (j != k && cfg_q[j][`STC_F_EN] &&
                cfg_q[j][`STC_F_KIND] == `STC_K_LOCK &&
                cfg_q[j][`STC_F_LINE] == cfg_q[k][`STC_F_LINE])
              ok_s[k] = 1'b0;
        end
        `STC_L_SWREQ:
        begin
          if (cfg_q[k][`STC_F_KIND] != `STC_K_LATEST)
            ok_s[k] = 1'b0;
        end
        `STC_L_OUT:
        begin
          if (cfg_q[k][`STC_F_KIND] != `STC_K_IVL &&
              cfg_q[k][`STC_F_KIND] != `STC_K_REF1HZ)
            ok_s[k] = 1'b0;
        end
        default:
          ok_s[k] = 1'b0;
      endcase
      bad_s[k] = cfg_q[k][`STC_F_EN] & ~ok_s[k];
      // Pick the trigger source for the slot
      case (cfg_q[k][`STC_F_LINE])
        `STC_L_IN0, `STC_L_IN1:
        begin
          case (cfg_q[k][`STC_F_POL])
            `STC_P_RISE:
              edge_s[k] = in_rise[cfg_q[k][1]];
            `STC_P_FALL:
              edge_s[k] = in_fall[cfg_q[k][1]];
            `STC_P_BOTH:
              edge_s[k] = in_rise[cfg_q[k][1]] |
                          in_fall[cfg_q[k][1]];
            default:
              edge_s[k] = 1'b0;
          endcase
        end
        `STC_L_SWREQ:
          edge_s[k] = swreq_q;
        `STC_L_OUT:
        begin
          // Reference mode locks to receiver pulse
          if (cfg_q[k][`STC_F_KIND] == `STC_K_REF1HZ)
            edge_s[k] = pps_rise;
          else
            edge_s[k] = ivl_tick_q;
        end
        default:
          edge_s[k] = 1'b0;
      endcase
      edge_s[k] = edge_s[k] & ok_s[k];
    end
  end

  // Function slots
  generate
    for (g = 0; g < `STC_SLOT_N; g = g + 1)
    begin : gsl
      stc_chan u_ch (
        .clk        (clk),
        .rst        (rst),
        .reload_i   (reload_q),
        .clr_once_i (meas_mode_enter),
        .us_tick_i  (us_tick_q),
        .edge_i     (edge_s[g]),
        .once_i     (cfg_q[g][`STC_F_ONCE]),
        .skipi_i    (cfg_q[g][`STC_F_SKIPI]),
        .skipp_i    (cfg_q[g][`STC_F_SKIPP]),
        .dly_i      (tim_q[g][`STC_F_DLY]),
        .wid_i      (tim_q[g][`STC_F_WID]),
        .fire_o     (fire[g]),
        .pulse_o    (pulse[g]),
        .spent_o    (spent[g])
      );
    end
  endgenerate

  // Output line and device-side events
  always @(posedge clk)
  begin
    if (rst)
    begin
      sync_output_line <= 1'b0;
      mark_event       <= 1'b0;
      latest_event     <= 1'b0;
      start_event      <= 1'b0;
      lock_event       <= 1'b0;
    end
    else
    begin
      sync_output_line <= 1'b0;
      mark_event       <= 1'b0;
      latest_event     <= 1'b0;
      start_event      <= 1'b0;
      lock_event       <= 1'b0;
      for (m = 0; m < `STC_SLOT_N; m = m + 1)
      begin
        if (cfg_q[m][`STC_F_LINE] == `STC_L_OUT)
        begin
          if (pulse[m] & ok_s[m])
            sync_output_line <= 1'b1;
        end
        else if (fire[m])
        begin
          case (cfg_q[m][`STC_F_KIND])
            `STC_K_MARK:
              mark_event <= 1'b1;
            `STC_K_LATEST:
              latest_event <= 1'b1;
            `STC_K_START:
              start_event <= 1'b1;
            `STC_K_LOCK:
              lock_event <= 1'b1;
            default:
              mark_event <= 1'b0;
          endcase
        end
      end
    end
  end

  // Wishbone register writes and ack
  always @(posedge clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      swreq_q  <= 1'b0;
      reload_q <= 1'b1;
      for (n = 0; n < `STC_SLOT_N; n = n + 1)
      begin
        cfg_q[n] <= `STC_CFG_RST;
        tim_q[n] <= `STC_TIM_RST;
      end
    end
    else
    begin
      wb_ack_o <= req;
      swreq_q  <= 1'b0;
      reload_q <= meas_mode_enter;
      if (req & wb_we_i)
      begin
        if (wb_adr_i == `STC_A_CTRL)
        begin
          // Control bits act as one-cycle strobes
          if (wb_sel_i[0])
          begin
            swreq_q  <= wb_dat_i[`STC_C_SWREQ];
            reload_q <= wb_dat_i[`STC_C_RELOAD] | meas_mode_enter;
          end
        end
        else if (is_slot)
        begin
          // Any slot write reloads all counters
          reload_q <= 1'b1;
          if (slot_tim)
            tim_q[slot_ix] <= (tim_q[slot_ix] & ~wmask) |
                              (wb_dat_i & wmask);
          else
            cfg_q[slot_ix] <= (cfg_q[slot_ix] & ~wmask) |
                              (wb_dat_i & wmask);
        end
      end
    end
  end

  // Wishbone read data
  always @(posedge clk)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (req)
    begin
      if (wb_adr_i == `STC_A_STAT)
        wb_dat_o <= {20'h00000, bad_s, spent,
                     1'b0, sync_output_line, in_lvl};
      else if (is_slot)
        wb_dat_o <= slot_tim ? tim_q[slot_ix] : cfg_q[slot_ix];
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end
endmodule

/* stc_top_asserts.sv */
// Purpose: Port-level checks for the sync trigger conditioner
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every stc_top instance
module stc_top_asserts (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Wishbone slave
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Sync lines
  input wire [1:0]  sync_input_line,
  input wire        receiver_second_pulse,
  input wire        sync_output_line,
  // Device side
  input wire        meas_mode_enter,
  input wire        mark_event,
  input wire        latest_event,
  input wire        start_event,
  input wire        lock_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A request the slave has not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Acknowledge lasting one cycle only
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_bus_answer:
    assert property (s_req |=> s_ans) else $error("ack not one cycle after request");
  a_ack_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_rdata_hold:
    assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o)) else $error("read data moved while idle");
  a_reset_quiet:
    assert property (@(posedge clk) disable iff (1'b0) rst |=> !(mark_event || latest_event || start_event
      || lock_event || sync_output_line || wb_ack_o)) else $error("output active after reset");
  a_mark_pulse:
    assert property (mark_event |=> !mark_event) else $error("mark event longer than one cycle");
  a_latest_pulse:
    assert property ($rose(latest_event) |=> $fell(latest_event)) else $error("latest event not a pulse");
  a_start_pulse:
    assert property (start_event |-> ##1 !start_event) else $error("start event not a pulse");
  a_lock_pulse:
    assert property (lock_event |=> !lock_event) else $error("lock event not a pulse");
endmodule

bind stc_top stc_top_asserts stc_top_asserts_inst (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sync_input_line(sync_input_line), .receiver_second_pulse(receiver_second_pulse),
  .sync_output_line(sync_output_line), .meas_mode_enter(meas_mode_enter), .mark_event(mark_event),
  .latest_event(latest_event), .start_event(start_event), .lock_event(lock_event)
);

/* stc_src.sv */
// Purpose: External trigger source and receiver second pulse
// Assumes: Lines change only just after rising clock edges
// Notes:   Lines are always driven and idle low
module stc_src (
  // Clock
  input  wire        clk,
  // Lines into the block
  output logic [1:0] line,
  output logic       pps
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle level from time zero
  initial
  begin
    line = 2'h0;
    pps = 1'b0;
  end
  // One pulse wave: high for hi cycles, then low for 20; k of 2 means second pulse
  task automatic pulse(input int k, input int hi);
    @(posedge clk);
    if (k == 2) pps <= 1'b1;
    else line[k] <= 1'b1;
    repeat (hi) @(posedge clk);
    line <= 2'h0;
    pps <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
endmodule

/* stc_tb.sv */
// Purpose: Self-checking bench for the sync trigger conditioner
// Assumes: Wishbone answer arrives after the request edge
// Notes:   Event counts are compared as differences, except the output rise count, which is compared as a total
`include "stc_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Design connections
  logic        clk = 1'b0;
  logic        rst, cyc, stb, we, meas;
  logic [7:0]  adr;
  logic [31:0] wdat, q;
  wire  [31:0] rdat;
  wire         ack, pps, sout, mark, lat, strt, lock;
  wire  [1:0]  sin;
  // Tallies and time stamps
  int          mismatches = 0, checks = 0, cyc_n = 0, b, b2, p;
  int          n_mark = 0, n_lat = 0, n_lock = 0, n_hi = 0, n_rise = 0;
  int          t_pin = 0, t_strt = 0, t_pps = 0, t_out = 0;
  logic        l0_q = 1'b0, o_q = 1'b0, p_q = 1'b0;
  // Free-running clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  stc_top stc_top_inst (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sync_input_line(sin), .receiver_second_pulse(pps), .sync_output_line(sout),
    .meas_mode_enter(meas), .mark_event(mark), .latest_event(lat), .start_event(strt), .lock_event(lock)
  );
  stc_src stc_src_inst (.clk(clk), .line(sin), .pps(pps));
  // Count events and stamp the moments of edges
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    n_mark <= n_mark + mark;
    n_lat <= n_lat + lat;
    n_lock <= n_lock + lock;
    n_hi <= n_hi + sout;
    n_rise <= n_rise + (sout && !o_q);
    if (sout && !o_q) t_out <= cyc_n;
    if (strt) t_strt <= cyc_n;
    if (sin[0] && !l0_q) t_pin <= cyc_n;
    if (pps && !p_q) t_pps <= cyc_n;
    l0_q <= sin[0];
    o_q <= sout;
    p_q <= pps;
  end
  // Verdict and end of run
  task automatic end_sim;
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (i == 20)
    begin
      mismatches++;
      end_sim();
    end
  endtask
  // Read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask
  // Program one slot: config word and timing word
  task automatic slot(input int k, input logic [31:0] c, input logic [31:0] tm);
    bus(1'b1, `STC_A_SLOT0 + 8'(8 * k), c);
    bus(1'b1, `STC_A_SLOT0 + 8'(8 * k + 4), tm);
  endtask
  // Build an enabled config word
  function automatic logic [31:0] mk(input logic [1:0] ln, input logic [1:0] pl, input logic on,
                                     input logic [2:0] kd, input logic [7:0] si, input logic [7:0] sp);
    mk = 32'h0000_0001;
    mk[`STC_F_LINE] = ln;
    mk[`STC_F_POL] = pl;
    mk[`STC_F_ONCE] = on;
    mk[`STC_F_KIND] = kd;
    mk[`STC_F_SKIPI] = si;
    mk[`STC_F_SKIPP] = sp;
  endfunction
  // Main sequence
  initial
  begin
    rst <= 1'b1;
    {cyc, stb, we, meas} <= 4'h0;
    adr <= 8'h00;
    wdat <= 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped and read-only places
    rdc(`STC_A_STAT, 32'h0);
    rdc(`STC_A_SLOT0, 32'h0);
    bus(1'b1, 8'h80, 32'hffff_ffff);
    rdc(8'h80, 32'h0);
    bus(1'b1, `STC_A_STAT, 32'hffff_ffff);
    rdc(`STC_A_STAT, 32'h0);
    // Each polarity code over three pulses
    for (p = 1; p < 4; p++)
    begin
      slot(0, mk(`STC_L_IN0, p[1:0], 1'b0, `STC_K_MARK, 8'h0, 8'h0), 32'h0);
      b = n_mark;
      repeat (3) stc_src_inst.pulse(0, 5);
      check(n_mark - b, p == 3 ? 6 : 3);
    end
    check(n_rise, 0);
    // Initial skip 2 then one skipped per accept
    slot(0, mk(`STC_L_IN0, `STC_P_RISE, 1'b0, `STC_K_MARK, 8'h2, 8'h1), 32'h0);
    b = n_mark;
    repeat (8) stc_src_inst.pulse(0, 5);
    check(n_mark - b, 3);
    // Single shot after one skipped edge, then cleared by mode entry
    slot(0, mk(`STC_L_IN0, `STC_P_RISE, 1'b1, `STC_K_MARK, 8'h1, 8'h0), 32'h0);
    b = n_mark;
    repeat (5) stc_src_inst.pulse(0, 5);
    check(n_mark - b, 1);
    bus(1'b0, `STC_A_STAT, 32'h0);
    check(q[4], 1'b1);
    @(posedge clk);
    meas <= 1'b1;
    @(posedge clk);
    meas <= 1'b0;
    repeat (2) stc_src_inst.pulse(0, 5);
    check(n_mark - b, 2);
    // Software request feeds only the send-latest kind
    slot(0, mk(`STC_L_SWREQ, `STC_P_RISE, 1'b0, `STC_K_LATEST, 8'h0, 8'h0), 32'h0);
    slot(1, mk(`STC_L_SWREQ, `STC_P_RISE, 1'b0, `STC_K_MARK, 8'h0, 8'h0), 32'h0);
    b = n_lat;
    b2 = n_mark;
    bus(1'b1, `STC_A_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    check(n_lat - b, 1);
    check(n_mark - b2, 0);
    bus(1'b0, `STC_A_STAT, 32'h0);
    check(q[9], 1'b1);
    // Clock lock owns its line
    slot(0, mk(`STC_L_IN1, `STC_P_RISE, 1'b0, `STC_K_LOCK, 8'h0, 8'h0), 32'h0);
    slot(1, mk(`STC_L_IN1, `STC_P_RISE, 1'b0, `STC_K_MARK, 8'h0, 8'h0), 32'h0);
    b = n_lock;
    b2 = n_mark;
    repeat (2) stc_src_inst.pulse(1, 5);
    check(n_lock - b, 2);
    check(n_mark - b2, 0);
    // One function listed once per input line
    slot(0, mk(`STC_L_IN0, `STC_P_RISE, 1'b0, `STC_K_MARK, 8'h0, 8'h0), 32'h0);
    slot(1, mk(`STC_L_IN1, `STC_P_FALL, 1'b0, `STC_K_MARK, 8'h0, 8'h0), 32'h0);
    b = n_mark;
    stc_src_inst.pulse(0, 5);
    stc_src_inst.pulse(1, 5);
    check(n_mark - b, 2);
    // Reaction delay of 5 us
    slot(1, 32'h0, 32'h0);
    slot(0, mk(`STC_L_IN0, `STC_P_RISE, 1'b0, `STC_K_START, 8'h0, 8'h0), 32'h0000_0005);
    stc_src_inst.pulse(0, 5);
    repeat (700) @(posedge clk);
    check(t_strt - t_pin >= 500 && t_strt - t_pin <= 620, 1);
    // Reference pulse of 3 us following the receiver second pulse
    slot(0, mk(`STC_L_OUT, `STC_P_RISE, 1'b0, `STC_K_REF1HZ, 8'h0, 8'h0), 32'h0003_0000);
    b = n_hi;
    stc_src_inst.pulse(2, 5);
    repeat (600) @(posedge clk);
    check(t_out - t_pps >= 0 && t_out - t_pps <= 110, 1);
    check(n_hi - b >= 290 && n_hi - b <= 400, 1);
    end_sim();
  end
endmodule
